// >>> hdl/tpu_timer.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R01) two instances: four and two channels; counter and values 16 bits
// (R02) each channel: capture, compare, edge PWM or center PWM
// (R03) any write to either counter byte clears counter and prescaler
// (R04) while halted, counter byte reads return the frozen live count
// (R05) while halted, control or counter write clears counter read latch
// (R06) while halted, channel value reads return the live value
// (R07) while halted, channel control write clears its value read latch
// (R08) in capture mode bus writes never alter the captured value
// (R09) compare mode, clock on: buffer loads at next prescaled count
// (R10) PWM, clock on: loads after both bytes, at modulo-1 to modulo
// (R11) free-running PWM: load at 0xfffe to 0xffff step
// (R12) clock source off: counter stops, full value write loads at once
// (R13) edge mode counts up, wraps to zero after reaching modulo
module tpu_timer
  import tpu_pkg::*;
#(
  parameter int unsigned NUM_CH = 4
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_BKGD_HALT,
  input wire logic I_FIX_CLK_EN,
  input wire logic I_EXT_CLK_EN,
  input wire logic [NUM_CH-1:0] I_CH_IN,
  output logic [NUM_CH-1:0] O_CH_OUT
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (NUM_CH < 1 || NUM_CH > MAX_CH)
  begin : g_bad
    $error("NUM_CH must be 1 to 4"); // R01
  end
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_m, rst_b;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      rst_m <= 1'b0;
      rst_b <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_b <= rst_m;
    end
  end
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic aw_held, w_held, wr_go, rd_go, wr_en, wr_ok, rd_ok;
  logic [7:0] aw_addr, wbyte, rd_byte;
  logic [3:0] w_strb;
  assign O_AWREADY = !aw_held;
  assign O_WREADY = !w_held;
  assign O_ARREADY = !O_RVALID;
  assign wr_go = aw_held && w_held && !O_BVALID;
  assign rd_go = I_ARVALID && !O_RVALID;
  assign wr_en = wr_go && w_strb[0] && wr_ok;
  always_ff @(posedge I_CLK_SYS or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      wbyte <= 8'h00;
      w_strb <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end
    else
    begin
      if (I_AWVALID && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= I_AWADDR[7:0];
      end
      if (I_WVALID && !w_held)
      begin
        w_held <= 1'b1;
        wbyte <= I_WDATA[7:0];
        w_strb <= I_WSTRB;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (I_BREADY)
        O_BVALID <= 1'b0;
    end
  end
  always_ff @(posedge I_CLK_SYS or negedge rst_b)
  begin
    if (!rst_b)
    begin
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      O_RVALID <= 1'b1;
      O_RDATA <= {24'h000000, rd_byte};
      O_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (I_RREADY)
      O_RVALID <= 1'b0;
  end
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic [3:0] w_idx, r_idx;
  logic wr_sc, wr_cnt, wr_modh, wr_modl, rd_cnth, rd_cntl;
  assign w_idx = 4'((aw_addr - A_CH_BASE) >> CH_SH);
  assign r_idx = 4'((I_ARADDR[7:0] - A_CH_BASE) >> CH_SH);
  always_comb
  begin
    case (aw_addr)
      A_SC, A_CNTH, A_CNTL, A_MODH, A_MODL: wr_ok = 1'b1;
      default: wr_ok = aw_addr >= A_CH_BASE && w_idx < 4'(NUM_CH)
        && (aw_addr[3:0] == A_CSC || aw_addr[3:0] == A_CVH
        || aw_addr[3:0] == A_CVL);
    endcase
  end
  assign wr_sc = wr_en && aw_addr == A_SC;
  assign wr_cnt = wr_en && (aw_addr == A_CNTH || aw_addr == A_CNTL);
  assign wr_modh = wr_en && aw_addr == A_MODH;
  assign wr_modl = wr_en && aw_addr == A_MODL;
  assign rd_cnth = rd_go && I_ARADDR[7:0] == A_CNTH;
  assign rd_cntl = rd_go && I_ARADDR[7:0] == A_CNTL;
  // ----------------------------------------
  // control, prescaler and counter
  // ----------------------------------------
  logic [7:0] sc;
  logic [15:0] cnt, modv, top, cnt_lat;
  logic [PRE_W-1:0] pre, pre_mask;
  logic tof, down, src_en, tick, cpwm, clk_off, upd_pwm, at_end;
  logic cnt_lat_v;
  assign cpwm = sc[SC_CPWM_BIT];
  assign clk_off = sc[SC_CLK_LSB +: 2] == CLK_OFF;
  assign pre_mask = PRE_W'((8'h01 << sc[SC_PS_LSB +: PS_W]) - 8'h01);
  always_comb
  begin
    case (sc[SC_CLK_LSB +: 2])
      CLK_BUS: src_en = 1'b1;
      CLK_FIX: src_en = I_FIX_CLK_EN;
      CLK_EXT: src_en = I_EXT_CLK_EN;
      default: src_en = 1'b0; // R12
    endcase
  end
  // debug halt freezes the count so reads see a stable value
  assign tick = src_en && !I_BKGD_HALT && (pre & pre_mask) == pre_mask;
  assign top = (modv == CNT_RST) ? CNT_FREE_TOP : modv;
  assign upd_pwm = tick && !down && cnt == top - CNT_ONE; // R10 R11
  assign at_end = cpwm ? (down && cnt == CNT_ONE) : cnt == top;
  always_ff @(posedge I_CLK_SYS or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sc <= SC_RST;
      modv <= CNT_RST;
    end
    else
    begin
      if (wr_sc)
        sc <= {1'b0, wbyte[6:0]};
      if (wr_modh)
        modv[15:8] <= wbyte;
      if (wr_modl)
        modv[7:0] <= wbyte;
    end
  end
  always_ff @(posedge I_CLK_SYS or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= CNT_RST;
      pre <= '0;
      down <= 1'b0;
    end
    else if (wr_cnt)
    begin
      cnt <= CNT_RST; // R03
      pre <= '0; // R03
      down <= 1'b0;
    end
    else if (src_en && !I_BKGD_HALT)
    begin
      pre <= ((pre & pre_mask) == pre_mask) ? '0 : pre + 1'b1;
      if (tick)
      begin
        if (!cpwm)
        begin
          down <= 1'b0;
          cnt <= (cnt == top) ? CNT_RST : cnt + CNT_ONE; // R13
        end
        else if (!down && cnt == top)
        begin
          down <= 1'b1;
          cnt <= cnt - CNT_ONE;
        end
        else if (down && cnt == CNT_RST)
        begin
          down <= 1'b0;
          cnt <= cnt + CNT_ONE;
        end
        else
          cnt <= down ? cnt - CNT_ONE : cnt + CNT_ONE;
      end
    end
  end
  // overflow flag: set wins over a clear written in the same cycle
  always_ff @(posedge I_CLK_SYS or negedge rst_b)
  begin
    if (!rst_b)
      tof <= 1'b0;
    else if (tick && at_end)
      tof <= 1'b1;
    else if (wr_sc && wbyte[FLAG_BIT])
      tof <= 1'b0;
  end
  // two-byte read latch for the counter
  always_ff @(posedge I_CLK_SYS or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_lat_v <= 1'b0;
      cnt_lat <= CNT_RST;
    end
    else if (I_BKGD_HALT)
    begin
      if (wr_sc || wr_cnt)
        cnt_lat_v <= 1'b0; // R05
    end
    else if (rd_cnth || rd_cntl)
    begin
      cnt_lat_v <= !cnt_lat_v;
      if (!cnt_lat_v)
        cnt_lat <= cnt;
    end
  end
  // ----------------------------------------
  // channels
  // ----------------------------------------
  logic [7:0] csc [NUM_CH];
  logic [15:0] cv [NUM_CH];
  logic [15:0] cv_lat [NUM_CH];
  logic cv_lat_v [NUM_CH];
  logic [NUM_CH-1:0] flags;
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    logic sel_w, sel_r, wr_csc, wr_h, wr_l, rd_v, hi_w, lo_w;
    logic in_q, edge_hit, match, apply, flag, out;
    logic [1:0] mode;
    logic [15:0] buf_v;
    assign sel_w = wr_en && aw_addr >= A_CH_BASE && w_idx == 4'(i);
    assign sel_r = rd_go && I_ARADDR[7:0] >= A_CH_BASE && r_idx == 4'(i);
    assign wr_csc = sel_w && aw_addr[3:0] == A_CSC;
    assign wr_h = sel_w && aw_addr[3:0] == A_CVH;
    assign wr_l = sel_w && aw_addr[3:0] == A_CVL;
    assign rd_v = sel_r && (I_ARADDR[3:0] == A_CVH
      || I_ARADDR[3:0] == A_CVL);
    assign flags[i] = flag;
    assign mode = csc[i][CSC_MODE_LSB +: 2]; // R02
    assign edge_hit = (mode == MODE_CAPTURE) && (csc[i][CSC_EDGE_BIT] ?
      (in_q && !I_CH_IN[i]) : (!in_q && I_CH_IN[i]));
    assign match = tick && cnt == cv[i];
    assign apply = hi_w && lo_w && (clk_off // R12
      || (mode == MODE_COMPARE && tick) // R09
      || (mode == MODE_PWM && upd_pwm)); // R10 R11
    always_ff @(posedge I_CLK_SYS or negedge rst_b)
    begin
      if (!rst_b)
      begin
        csc[i] <= CSC_RST;
        in_q <= 1'b0;
        flag <= 1'b0;
      end
      else
      begin
        in_q <= I_CH_IN[i];
        if (wr_csc)
          csc[i] <= {1'b0, wbyte[6:0]};
        if (edge_hit || (mode != MODE_CAPTURE && match))
          flag <= 1'b1;
        else if (wr_csc && wbyte[FLAG_BIT])
          flag <= 1'b0;
      end
    end
    // write buffer: the value moves on at the mode's update point, or at once with the clock off
    always_ff @(posedge I_CLK_SYS or negedge rst_b)
    begin
      if (!rst_b)
      begin
        hi_w <= 1'b0;
        lo_w <= 1'b0;
        buf_v <= CNT_RST;
        cv[i] <= CNT_RST;
      end
      else
      begin
        if (edge_hit)
          cv[i] <= cnt;
        else if (apply && mode != MODE_CAPTURE)
          cv[i] <= buf_v;
        if (wr_csc || mode == MODE_CAPTURE || apply)
        begin
          hi_w <= 1'b0; // R08
          lo_w <= 1'b0;
        end
        else
        begin
          if (wr_h)
          begin
            buf_v[15:8] <= wbyte;
            hi_w <= 1'b1;
          end
          if (wr_l)
          begin
            buf_v[7:0] <= wbyte;
            lo_w <= 1'b1;
          end
        end
      end
    end
    always_ff @(posedge I_CLK_SYS or negedge rst_b)
    begin
      if (!rst_b)
      begin
        cv_lat_v[i] <= 1'b0;
        cv_lat[i] <= CNT_RST;
      end
      else if (I_BKGD_HALT)
      begin
        if (wr_csc)
          cv_lat_v[i] <= 1'b0; // R07
      end
      else if (rd_v)
      begin
        cv_lat_v[i] <= !cv_lat_v[i];
        if (!cv_lat_v[i])
          cv_lat[i] <= cv[i];
      end
    end
    always_ff @(posedge I_CLK_SYS or negedge rst_b)
    begin
      if (!rst_b)
        out <= 1'b0;
      else if (mode == MODE_COMPARE)
      begin
        if (match)
          out <= !out;
      end
      else if (mode == MODE_PWM)
        out <= cnt < cv[i];
      else
        out <= 1'b0;
    end
    assign O_CH_OUT[i] = out;
  end
  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [15:0] cnt_view, cv_view;
  always_comb
  begin
    cv_view = CNT_RST;
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    // halted reads bypass the latches so a debugger sees true state
    cnt_view = (I_BKGD_HALT || !cnt_lat_v) ? cnt : cnt_lat; // R04
    for (int k = 0; k < NUM_CH; k++)
    begin
      if (r_idx == 4'(k))
        cv_view = (I_BKGD_HALT || !cv_lat_v[k]) ? cv[k] : cv_lat[k]; // R06
    end
    case (I_ARADDR[7:0])
      A_SC: rd_byte = {tof, sc[6:0]};
      A_CNTH: rd_byte = cnt_view[15:8];
      A_CNTL: rd_byte = cnt_view[7:0];
      A_MODH: rd_byte = modv[15:8];
      A_MODL: rd_byte = modv[7:0];
      default:
      begin
        rd_ok = 1'b0;
        for (int k = 0; k < NUM_CH; k++)
        begin
          if (I_ARADDR[7:0] >= A_CH_BASE && r_idx == 4'(k))
          begin
            rd_ok = 1'b1;
            case (I_ARADDR[3:0])
              A_CSC: rd_byte = {flags[k], csc[k][6:0]};
              A_CVH: rd_byte = cv_view[15:8];
              A_CVL: rd_byte = cv_view[7:0];
              default: rd_ok = 1'b0;
            endcase
          end
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> hdl/tpu_pkg.sv
package tpu_pkg;
  // ----------------------------------------
  // register map, one byte per aligned word
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned MAX_CH = 4;
  localparam logic [7:0] A_SC = 8'h00;
  localparam logic [7:0] A_CNTH = 8'h04;
  localparam logic [7:0] A_CNTL = 8'h08;
  localparam logic [7:0] A_MODH = 8'h0c;
  localparam logic [7:0] A_MODL = 8'h10;
  localparam logic [7:0] A_CH_BASE = 8'h20;
  localparam int unsigned CH_SH = 4;
  localparam logic [3:0] A_CSC = 4'h0;
  localparam logic [3:0] A_CVH = 4'h4;
  localparam logic [3:0] A_CVL = 4'h8;
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int unsigned SC_PS_LSB = 0;
  localparam int unsigned PS_W = 3;
  localparam int unsigned PRE_W = 7;
  localparam int unsigned SC_CLK_LSB = 3;
  localparam int unsigned SC_CPWM_BIT = 5;
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned CSC_MODE_LSB = 0;
  localparam int unsigned CSC_EDGE_BIT = 2;
  localparam logic [7:0] SC_RST = 8'h00;
  localparam logic [7:0] CSC_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_FREE_TOP = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_FIX = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [1:0] MODE_COMPARE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> verif/tpu_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tpu_timer_assertions
  import tpu_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP
);
  // ----------------------------------------
  // register bus handshakes
  // ----------------------------------------
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);
  a_bresp_stands: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write answer dropped");
  a_rdata_stands: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA)) else $error("read answer dropped");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_ar_refused: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read taken while answer pending");
  a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID &&
    O_WREADY |-> ##2 O_BVALID) else $error("write answer late");
  a_rdata_byte: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_err_data: assert property (O_RVALID && O_RRESP == RESP_SLVERR |->
    O_RDATA == 32'h0) else $error("refused read carries data");
  a_reset_quiet: assert property ($rose(I_RST_B) |-> !O_BVALID && !O_RVALID)
    else $error("answer pending out of reset");
endmodule
bind tpu_timer tpu_timer_assertions u_chk (.I_CLK_SYS, .I_RST_B, .I_AWVALID,
  .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY, .O_BRESP,
  .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP);
`default_nettype wire

// >>> verif/tpu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpu_pin_model
#(
  parameter int unsigned NUM_CH = 4
)
(
  input wire logic i_clk,
  output logic o_fix_en,
  output logic o_ext_en,
  output logic [NUM_CH-1:0] o_ch_in
);
  // fixed-rate source pulses one cycle in four; external source idle
  logic [1:0] div = 2'h0;
  always_ff @(posedge i_clk) div <= div + 2'h1;
  assign o_fix_en = (div == 2'h3);
  assign o_ext_en = 1'b0;
  // pins held quiet so no capture edge disturbs stored values
  assign o_ch_in = '0;
endmodule
`default_nettype wire

// >>> verif/test_timer_pwm_channel_update.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer_pwm_channel_update
  import tpu_pkg::*;
;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  localparam logic [7:0] CSC0 = A_CH_BASE | {4'h0, A_CSC};
  localparam logic [7:0] CVH0 = A_CH_BASE | {4'h0, A_CVH};
  localparam logic [7:0] CVL0 = A_CH_BASE | {4'h0, A_CVL};
  localparam logic [7:0] SC_FAST = {3'h0, CLK_BUS, 3'h0};
  localparam logic [7:0] SC_SLOW = {3'h0, CLK_BUS, 3'h7};
  localparam int CEIL = 10000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, halt = 1'b0, fix_en, ext_en;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, d, v1, v2;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] r, bresp, rresp;
  logic [3:0] ch_in, ch_out;
  int failures = 0, total_checks = 0, cycles = 0;
  always #50 clk = ~clk;
  tpu_timer #(.NUM_CH(4)) u_dut (.I_CLK_SYS(clk), .I_RST_B(rst_b),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
    .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
    .I_WSTRB(4'h1), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_RDATA(rdata), .O_RRESP(rresp), .I_BKGD_HALT(halt),
    .I_FIX_CLK_EN(fix_en), .I_EXT_CLK_EN(ext_en), .I_CH_IN(ch_in),
    .O_CH_OUT(ch_out));
  tpu_pin_model #(.NUM_CH(4)) u_pins (.i_clk(clk), .o_fix_en(fix_en),
    .o_ext_en(ext_en), .o_ch_in(ch_in));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // handshakes are sampled at the rising edge, before that edge's updates
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic b;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, v};
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      b = bvalid;
    end while (!b);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v,
                    output logic [1:0] rs);
    logic ok;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      ok = rvalid;
      v = rdata[7:0];
      rs = rresp;
    end while (!ok);
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(v, e);
  endtask
  task automatic stop_test();
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == CEIL)
    begin
      failures++;
      stop_test();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    wr(A_MODH, 8'h00);
    wr(A_MODL, 8'h10);
    wr(A_SC, SC_FAST);
    repeat (40) @(posedge clk);
    wr(A_SC, SC_RST);
    wr(A_CNTH, 8'h5a);
    rc(A_CNTH, 8'h00);
    rc(A_CNTL, 8'h00);
    wr(CSC0, {6'h0, MODE_COMPARE});
    wr(CVH0, 8'h12);
    wr(CVL0, 8'h34);
    rc(CVH0, 8'h12);
    rc(CVL0, 8'h34);
    wr(CSC0, {6'h0, MODE_CAPTURE});
    wr(CVH0, 8'hff);
    wr(CVL0, 8'hff);
    rc(CVH0, 8'h12);
    rc(CVL0, 8'h34);
    // slow prescaler leaves room to see the old value before the load
    wr(A_SC, SC_SLOW);
    wr(CSC0, {6'h0, MODE_COMPARE});
    wr(A_CNTL, 8'h00);
    wr(CVH0, 8'h00);
    wr(CVL0, 8'h09);
    rc(CVH0, 8'h12);
    rc(CVL0, 8'h34);
    repeat (130) @(posedge clk);
    rc(CVH0, 8'h00);
    rc(CVL0, 8'h09);
    wr(CSC0, {6'h0, MODE_PWM});
    wr(A_CNTL, 8'h00);
    wr(CVH0, 8'h00);
    wr(CVL0, 8'h05);
    repeat (14 * 128) @(posedge clk);
    rc(CVH0, 8'h00);
    rc(CVL0, 8'h09);
    repeat (3 * 128) @(posedge clk);
    rc(CVH0, 8'h00);
    rc(CVL0, 8'h05);
    wr(A_SC, SC_FAST);
    rd(A_CNTH, d, r);
    @(posedge clk);
    halt <= 1'b1;
    rd(A_CNTL, v1, r);
    repeat (20) @(posedge clk);
    rd(A_CNTL, v2, r);
    chk(v2, v1);
    wr(A_SC, SC_RST);
    @(posedge clk);
    halt <= 1'b0;
    rc(A_CNTL, v1);
    rc(A_CNTH, 8'h00);
    // leave a half-read value latch, then move the value while halted
    rc(CVH0, 8'h00);
    @(posedge clk);
    halt <= 1'b1;
    wr(CVH0, 8'h00);
    wr(CVL0, 8'h07);
    rc(CVL0, 8'h07);
    wr(CSC0, {6'h0, MODE_PWM});
    @(posedge clk);
    halt <= 1'b0;
    rc(CVL0, 8'h07);
    rc(CVH0, 8'h00);
    rd(8'hfc, d, r);
    chk({6'h0, r}, {6'h0, RESP_SLVERR});
    chk(d, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
